// ==== rtl/fbop_pkg.sv ====
package fbop_pkg;
  // data pin and address widths
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 17;
  localparam int TOP_PIN = 15;
  // clock rate in kHz
  localparam int CLK_KHZ = 10000;
  // timing figures in ns, plain defaults
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_HIGH_TO_READ_NS = 50;
  localparam int SELECT_ACCESS_TIME_NS = 120;
  localparam int STROBE_NS = 100;
  // least times round up to whole cycles, never below one
  function automatic int fbop_cyc_up(input int ns);
    int c;
    c = (ns * (CLK_KHZ / 1000) + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : fbop_cyc_up
  localparam int RP_CYC = fbop_cyc_up(RESET_PULSE_MIN_NS);
  localparam int RH_CYC = fbop_cyc_up(RESET_HIGH_TO_READ_NS);
  localparam int CE_CYC = fbop_cyc_up(SELECT_ACCESS_TIME_NS);
  localparam int WR_CYC = fbop_cyc_up(STROBE_NS);
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  // controller states
  typedef enum logic [2:0] {
    FBOP_IDLE = 3'b000,
    FBOP_RST = 3'b001,
    FBOP_RCVR = 3'b010,
    FBOP_RD = 3'b011,
    FBOP_WR = 3'b100,
    FBOP_WREND = 3'b101
  } fbop_state_e;
endpackage : fbop_pkg

// ==== rtl/fbop_pins_if.sv ====
`timescale 1ns/1ns
// pin-level signals shared between the sequencer and pin driver
interface fbop_pins_if;
  logic [15:0] dq_o;
  logic [15:0] dq_oe;
  logic [15:0] dq_i;
  logic word_mode;
  logic byte_lsb;
  modport seq(output dq_o, output word_mode, output byte_lsb, input dq_i);
  modport drv(input dq_o, input word_mode, input byte_lsb, output dq_oe, output dq_i);
endinterface : fbop_pins_if

// ==== rtl/fbop_dq_drv.sv ====
`timescale 1ns/1ns
// data pin enables and two-stage input sync
module fbop_dq_drv (
  // clock and control
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic drive_in,
  // pin side
  input wire logic [15:0] pin_in,
  fbop_pins_if.drv pins
);
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic [15:0] oe_w; // decoded pin enables
  ////////////////////////////////////////////////////////////////////////
  // enables: byte mode leaves 8..14 floating, 15 carries the lsb
  // decoded without a flop: the top module registers them once, so data
  // reaches the pins one cycle late, at the edge where the write strobe rises
  always_comb begin
    if (!drive_in) begin
      oe_w = 16'h0000;
    end else if (pins.word_mode) begin
      oe_w = 16'hFFFF;
    end else begin
      oe_w = 16'h80FF;
    end
  end
  // top pin always driven as address in byte mode
  assign pins.dq_oe = oe_w | {~pins.word_mode, 15'h0000};
  ////////////////////////////////////////////////////////////////////////
  // pins are asynchronous: two flops before use
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else if (ce_in) begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end
  assign pins.dq_i = sync2_r;
endmodule : fbop_dq_drv

// ==== rtl/fbop_ctrl.sv ====
`timescale 1ns/1ns
module fbop_ctrl (
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // user request port
  input wire logic req_rd_in,
  input wire logic req_wr_in,
  input wire logic req_reset_in,
  input wire logic word_mode_in,
  input wire logic [16:0] addr_in,
  input wire logic byte_lsb_in,
  input wire logic [15:0] wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] rdata_out,
  output logic dev_ready_out,
  // flash pins
  output logic [16:0] addr_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic reset_n_out,
  output logic byte_n_out,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_oe_out,
  input wire logic ready_busy_n_in
);
  fbop_pins_if pins ();
  fbop_pkg::fbop_state_e state_r;
  logic [fbop_pkg::CNT_W-1:0] cnt_r;
  logic rb_s1_r;
  logic rb_s2_r;
  logic drive_r;
  logic word_r;
  logic lsb_r;
  logic [15:0] wdata_r;
  logic [15:0] dq_w;
  ////////////////////////////////////////////////////////////////////////
  // pin driver instance
  fbop_dq_drv u_drv (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .ce_in(clk_en_in),
    .drive_in(drive_r),
    .pin_in(dq_in),
    .pins(pins)
  );
  assign pins.word_mode = word_r;
  assign pins.byte_lsb = lsb_r;
  // top pin carries byte lsb in byte mode
  assign pins.dq_o = word_r ? wdata_r : {lsb_r, 7'h00, wdata_r[7:0]};
  ////////////////////////////////////////////////////////////////////////
  // ready/busy pin sync, two flops
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else if (clk_en_in) begin
      rb_s1_r <= ready_busy_n_in;
      rb_s2_r <= rb_s1_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // sequencer: reset pulse, recovery, read and write strobes
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state_r <= fbop_pkg::FBOP_RST; // device reset on our reset too
      cnt_r <= fbop_pkg::CNT_ZERO;
      ce_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      we_n_out <= 1'b1;
      reset_n_out <= 1'b0;
      drive_r <= 1'b0;
      word_r <= 1'b1;
      lsb_r <= 1'b0;
      wdata_r <= 16'h0000;
      addr_out <= 17'h00000;
      byte_n_out <= 1'b1;
      busy_out <= 1'b1;
      done_out <= 1'b0;
      rdata_out <= 16'h0000;
    end else if (clk_en_in) begin
      done_out <= 1'b0;
      unique case (state_r)
        fbop_pkg::FBOP_IDLE: begin
          // idle: select high, pins float except the top pin in byte mode, standby
          ce_n_out <= 1'b1;
          oe_n_out <= 1'b1;
          busy_out <= 1'b0;
          if (req_reset_in) begin
            reset_n_out <= 1'b0;
            cnt_r <= fbop_pkg::CNT_ZERO;
            busy_out <= 1'b1;
            state_r <= fbop_pkg::FBOP_RST;
          end else if (req_rd_in) begin
            addr_out <= addr_in;
            word_r <= word_mode_in;
            byte_n_out <= word_mode_in;
            lsb_r <= byte_lsb_in;
            drive_r <= 1'b0; // device owns the data pins; top pin stays address in byte mode
            ce_n_out <= 1'b0;
            oe_n_out <= 1'b0;
            we_n_out <= 1'b1;
            cnt_r <= fbop_pkg::CNT_ZERO;
            busy_out <= 1'b1;
            state_r <= fbop_pkg::FBOP_RD;
          end else if (req_wr_in) begin
            addr_out <= addr_in; // sector in upper bits
            word_r <= word_mode_in;
            byte_n_out <= word_mode_in;
            lsb_r <= byte_lsb_in;
            wdata_r <= wdata_in;
            drive_r <= 1'b1;
            ce_n_out <= 1'b0;
            oe_n_out <= 1'b1;
            we_n_out <= 1'b0;
            cnt_r <= fbop_pkg::CNT_ZERO;
            busy_out <= 1'b1;
            state_r <= fbop_pkg::FBOP_WR;
          end
        end
        fbop_pkg::FBOP_RST: begin
          // hold reset low for the minimum pulse width
          reset_n_out <= 1'b0;
          ce_n_out <= 1'b1;
          drive_r <= 1'b0;
          cnt_r <= cnt_r + fbop_pkg::CNT_ONE;
          if (cnt_r >= 8'(fbop_pkg::RP_CYC - 1)) begin
            reset_n_out <= 1'b1;
            cnt_r <= fbop_pkg::CNT_ZERO;
            state_r <= fbop_pkg::FBOP_RCVR;
          end
        end
        fbop_pkg::FBOP_RCVR: begin
          // wait high-to-read time and ready/busy high
          if (cnt_r < 8'(fbop_pkg::RH_CYC + 2)) begin
            cnt_r <= cnt_r + fbop_pkg::CNT_ONE;
          end else if (rb_s2_r) begin
            done_out <= 1'b1; // user may reissue
            state_r <= fbop_pkg::FBOP_IDLE;
          end
        end
        fbop_pkg::FBOP_RD: begin
          // full access time from select low, covers standby exit
          cnt_r <= cnt_r + fbop_pkg::CNT_ONE;
          if (cnt_r >= 8'(fbop_pkg::CE_CYC + 1)) begin
            rdata_out <= word_r ? pins.dq_i : {8'h00, pins.dq_i[7:0]};
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            drive_r <= 1'b0;
            done_out <= 1'b1;
            state_r <= fbop_pkg::FBOP_IDLE;
          end
        end
        fbop_pkg::FBOP_WR: begin
          // write strobe width
          cnt_r <= cnt_r + fbop_pkg::CNT_ONE;
          if (cnt_r >= 8'(fbop_pkg::WR_CYC - 1)) begin
            we_n_out <= 1'b1;
            state_r <= fbop_pkg::FBOP_WREND;
          end
        end
        fbop_pkg::FBOP_WREND: begin
          // data held two cycles past write rise
          ce_n_out <= 1'b1;
          drive_r <= 1'b0;
          done_out <= 1'b1;
          state_r <= fbop_pkg::FBOP_IDLE;
        end
        default: state_r <= fbop_pkg::FBOP_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // ready flag and registered pin outputs
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      dev_ready_out <= 1'b0;
      dq_out <= 16'h0000;
      dq_oe_out <= 16'h0000;
    end else if (clk_en_in) begin
      dev_ready_out <= rb_s2_r;
      dq_out <= dq_w;
      dq_oe_out <= pins.dq_oe;
    end
  end
  assign dq_w = pins.dq_o;
endmodule : fbop_ctrl

// ==== sim/fbop_ctrl_properties.sv ====
`timescale 1ns/1ns
// pin sequencing seen from the controller top ports
module fbop_ctrl_properties (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // flash pins
  input wire logic ce_n_out,
  input wire logic oe_n_out,
  input wire logic we_n_out,
  input wire logic reset_n_out,
  input wire logic [15:0] dq_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////
  // strobe combinations
  chk_read_strobes: assert property (!oe_n_out |-> !ce_n_out && we_n_out)
    else $error("read strobes wrong");
  chk_write_strobes: assert property (!we_n_out |-> !ce_n_out && oe_n_out)
    else $error("write strobes wrong");
  // host must not fight the device data outputs; top pin may carry the lsb
  chk_read_nodrive: assert property (!oe_n_out |-> dq_oe_out[14:0] == 15'h0000)
    else $error("data driven during read");
  chk_read_len: assert property ($fell(oe_n_out) |-> !oe_n_out [*4] ##1 oe_n_out)
    else $error("read too short");
  chk_write_len: assert property ($fell(we_n_out) |=> we_n_out && !ce_n_out ##1 ce_n_out)
    else $error("write cycle shape wrong");
  ////////////////////////////////////////
  // hardware reset pulse and recovery
  chk_reset_quiet: assert property (!reset_n_out |-> ce_n_out && oe_n_out && we_n_out)
    else $error("strobes during reset");
  chk_reset_width: assert property ($fell(reset_n_out) |-> !reset_n_out [*5])
    else $error("reset pulse short");
  chk_reset_read: assert property ($rose(reset_n_out) |-> oe_n_out && ce_n_out)
    else $error("read too soon after reset");
endmodule : fbop_ctrl_properties

// ==== sim/fbop_flash_model.sv ====
`timescale 1ns/1ns
// behavioural flash: array read, program with busy time, hardware reset
module fbop_flash_model (
  // clock for busy timing
  input wire logic clock_in,
  // pins from the host
  input wire logic [16:0] addr_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic reset_n_in,
  input wire logic byte_n_in,
  input wire logic [15:0] dq_in,
  // device outputs
  output logic [15:0] dq_out,
  output logic ready_busy_n_out
);
  logic [15:0] mem_r [16]; // small window of the array
  logic [15:0] pend_r, last_r, wv, wd; // pending data, last driven, merge, read word
  logic [7:0] bv; // selected byte
  logic [4:0] cnt_r; // busy countdown
  logic prog_r, we_q, rd;
  logic [3:0] pa_r;
  initial begin
    for (int i = 0; i < 16; i++) mem_r[i] = 16'hFFFF;
    cnt_r = 5'h00;
    prog_r = 1'b0;
    we_q = 1'b1;
    last_r = 16'h0000;
  end
  ////////////////////////////////////////
  // program latch, busy count, abort on reset
  always @(posedge clock_in) begin
    we_q <= we_n_in;
    last_r <= dq_out;
    if (!reset_n_in) begin
      prog_r <= 1'b0;
      if (cnt_r != 5'h00) cnt_r <= 5'h08;
    end else if (!we_q && we_n_in && !ce_n_in) begin
      pa_r <= addr_in[3:0];
      pend_r <= wv;
      prog_r <= 1'b1;
      cnt_r <= 5'h14;
    end else if (cnt_r != 5'h00) begin // runs on while deselected
      cnt_r <= cnt_r - 5'h01;
      if (cnt_r == 5'h01 && prog_r) mem_r[pa_r] <= pend_r;
    end
  end
  ////////////////////////////////////////
  // output pins; released lines show the inverse of the last value
  always_comb begin
    wd = mem_r[addr_in[3:0]];
    wv = byte_n_in ? dq_in : (dq_in[15] ? {dq_in[7:0], wd[7:0]} : {wd[15:8], dq_in[7:0]});
    rd = !ce_n_in && !oe_n_in && we_n_in && reset_n_in;
    if (cnt_r != 5'h00) wd = 16'h0008;
    bv = dq_in[15] ? wd[15:8] : wd[7:0];
    if (!rd) dq_out = ~last_r;
    else if (byte_n_in) dq_out = wd;
    else dq_out = {~last_r[15:8], bv};
  end
  assign ready_busy_n_out = (cnt_r == 5'h00);
endmodule : fbop_flash_model

// ==== sim/flash_bus_operation_control_tb_top.sv ====
`timescale 1ns/1ns
// directed bench: controller against the flash model
module flash_bus_operation_control_tb_top;
  typedef struct packed {
    logic [1:0] op; // 0 read, 1 write, 2 reset
    logic wm;
    logic [3:0] a;
    logic ls;
    logic [15:0] d;
    logic [15:0] e;
  } fbop_row_s;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic req_rd_in = 1'b0;
  logic req_wr_in = 1'b0;
  logic req_reset_in = 1'b0;
  logic word_mode_in = 1'b1;
  logic [16:0] addr_in = 17'h00000;
  logic byte_lsb_in = 1'b0;
  logic [15:0] wdata_in = 16'h0000;
  logic busy_out, done_out, dev_ready_out, ce_n_out, oe_n_out, we_n_out, reset_n_out;
  logic byte_n_out, rb_n;
  logic [15:0] rdata_out, dq_out, dq_oe_out, m_dq, dq_w;
  logic [16:0] addr_out;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  fbop_row_s rows [7];
  assign dq_w = (dq_oe_out & dq_out) | (~dq_oe_out & m_dq); // wire level of the data pins
  fbop_ctrl i_dut (.clock_in, .rstn_in, .clk_en_in, .req_rd_in, .req_wr_in,
    .req_reset_in, .word_mode_in, .addr_in, .byte_lsb_in, .wdata_in, .busy_out, .done_out,
    .rdata_out, .dev_ready_out, .addr_out, .ce_n_out, .oe_n_out, .we_n_out, .reset_n_out,
    .byte_n_out, .dq_in(dq_w), .dq_out, .dq_oe_out, .ready_busy_n_in(rb_n));
  fbop_flash_model i_flash (.clock_in, .addr_in(addr_out), .ce_n_in(ce_n_out),
    .oe_n_in(oe_n_out), .we_n_in(we_n_out), .reset_n_in(reset_n_out), .byte_n_in(byte_n_out),
    .dq_in(dq_w), .dq_out(m_dq), .ready_busy_n_out(rb_n));
  initial forever #50 clock_in = ~clock_in;
  // hang guard
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // bounded wait on busy (0), done (1) or ready (2)
  task automatic wait_for(input int s, input logic v);
    logic [2:0] st;
    for (int k = 0; k < 400; k++) begin
      @(negedge clock_in);
      st = {dev_ready_out, done_out, busy_out};
      if (st[s] === v) return;
    end
    chk({15'h0000, st[s]}, {15'h0000, v}, "wait_state");
  endtask : wait_for
  // one request held until taken, then dropped while busy
  task automatic op(input fbop_row_s r);
    @(posedge clock_in);
    word_mode_in <= r.wm;
    addr_in <= {13'h0000, r.a};
    byte_lsb_in <= r.ls;
    wdata_in <= r.d;
    req_rd_in <= (r.op == 2'h0);
    req_wr_in <= (r.op == 2'h1);
    req_reset_in <= (r.op == 2'h2);
    wait_for(0, 1'b1);
    @(posedge clock_in);
    req_rd_in <= 1'b0;
    req_wr_in <= 1'b0;
    req_reset_in <= 1'b0;
    wait_for(1, 1'b1);
  endtask : op
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  // main sequence
  initial begin
    rows = '{'{2'h0, 1'b1, 4'h0, 1'b0, 16'h0000, 16'hFFFF}, '{2'h1, 1'b1, 4'h1, 1'b0, 16'hA55A,
      16'h0000}, '{2'h0, 1'b1, 4'h1, 1'b0, 16'h0000, 16'hA55A}, '{2'h0, 1'b0, 4'h1, 1'b0,
      16'h0000, 16'h005A}, '{2'h0, 1'b0, 4'h1, 1'b1, 16'h0000, 16'h00A5}, '{2'h1, 1'b0, 4'h2,
      1'b1, 16'h0033, 16'h0000}, '{2'h0, 1'b1, 4'h2, 1'b0, 16'h0000, 16'h33FF}};
    repeat (12) @(posedge clock_in);
    rstn_in <= 1'b1;
    wait_for(0, 1'b0);
    chk({15'h0000, dev_ready_out}, 16'h0001, "ready_after_reset");
    $display("test reset done");
    foreach (rows[i]) begin
      op(rows[i]);
      if (rows[i].op == 2'h0) chk(rdata_out, rows[i].e, "rdata");
      else begin
        wait_for(2, 1'b0);
        wait_for(2, 1'b1);
      end
    end
    $display("test table done");
    // frozen controller stays idle and takes no request until enabled
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    word_mode_in <= 1'b1;
    addr_in <= 17'h00001;
    req_rd_in <= 1'b1;
    repeat (6) @(negedge clock_in);
    chk({15'h0000, busy_out}, 16'h0000, "frozen_busy");
    chk({15'h0000, oe_n_out}, 16'h0001, "frozen_oe");
    @(posedge clock_in);
    clk_en_in <= 1'b1;
    wait_for(0, 1'b1);
    @(posedge clock_in);
    req_rd_in <= 1'b0;
    wait_for(1, 1'b1);
    chk(rdata_out, 16'hA55A, "thawed_read");
    $display("test freeze done");
    // read while programming, then reset aborts the program
    op('{2'h1, 1'b1, 4'h3, 1'b0, 16'h0F0F, 16'h0000});
    op('{2'h0, 1'b1, 4'h3, 1'b0, 16'h0000, 16'h0000});
    chk(rdata_out, 16'h0008, "status");
    op('{2'h2, 1'b1, 4'h0, 1'b0, 16'h0000, 16'h0000});
    chk({15'h0000, dev_ready_out}, 16'h0001, "ready_after_abort");
    op('{2'h0, 1'b1, 4'h3, 1'b0, 16'h0000, 16'h0000});
    chk(rdata_out, 16'hFFFF, "aborted_word");
    op('{2'h1, 1'b1, 4'h3, 1'b0, 16'h0F0F, 16'h0000}); // restart
    wait_for(2, 1'b0);
    wait_for(2, 1'b1);
    op('{2'h0, 1'b1, 4'h3, 1'b0, 16'h0000, 16'h0000});
    chk(rdata_out, 16'h0F0F, "restarted_word");
    $display("test abort done");
    final_report();
  end
endmodule : flash_bus_operation_control_tb_top
bind fbop_ctrl fbop_ctrl_properties i_chk (.clock_in, .rstn_in, .ce_n_out, .oe_n_out,
  .we_n_out, .reset_n_out, .dq_oe_out);
